//--- port_b_low_map.svh
// Register offsets, reset values and field positions of the low port pin block
`ifndef PORT_B_LOW_MAP_SVH
`define PORT_B_LOW_MAP_SVH

`define PBL_ADDR_W 6
`define PBL_OFS_LATCH 6'h00
`define PBL_OFS_DIR 6'h04
`define PBL_OFS_INPUT 6'h08
`define PBL_OFS_ANALOG 6'h0C
`define PBL_OFS_ICON2 6'h10
`define PBL_OFS_FUNC 6'h14

`define PBL_RST_LATCH 4'h0
`define PBL_RST_DIR 4'hF
`define PBL_RST_DIGITAL 4'h0
`define PBL_RST_PU_DIS_N 1'b1
`define PBL_RST_OE_N 4'hF

`define PBL_BIT_PU_DIS_N 7
`define PBL_BIT_FUNC_PP 4
`define PBL_BIT_FUNC_REF 5

`define PBL_PIN_IRQ 0
`define PBL_PIN_BE 1
`define PBL_PIN_A3 2
`define PBL_PIN_A2 3
`define PBL_PIN_REF 2

`define PBL_RESP_OKAY 2'h0
`define PBL_RESP_SLVERR 2'h2

`endif

//--- port_b_pkg.sv
// Types shared by the low port pin block
`include "port_b_low_map.svh"
package port_b_pkg;

    typedef struct packed {
        logic [`PBL_ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`PBL_ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef enum logic [2:0] {
        FN_GPIO,
        FN_REMAP,
        FN_PARALLEL,
        FN_REFCLK,
        FN_DEBUG
    } pin_func_t;

    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] dir;
        logic [3:0] digital;
        logic pu_dis_n;
        logic [3:0] remap_en;
        logic pp_en;
        logic ref_en;
        logic aw_held;
        logic [`PBL_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [3:0] pin_out;
        logic [3:0] pin_oe_n;
        logic [3:0] pullup_en;
        logic [3:0] remap_in;
        logic irq0;
    } port_state_t;

endpackage

//--- pin_sync.sv
// Two-stage synchroniser for the digital pin inputs
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // First stage feeds only the second one
    always_comb begin
        next_st = st;
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;
endmodule

//--- port_b_low_pin_function_mux.sv
// Pin function mux and register slave for the four low port pins
//
// Notes on behaviour
// - Direction 0 drives the output latch; analog setting leaves the drive alone.
// - Direction 1 makes an input; pull-up on while shared active-low bit is clear.
// - Analog pins have their digital input path shut off.
// - After reset pins are analog; setting config bits makes them digital.
// - Debug-claimed pins lose every other function.
// - Parallel port outputs override the direction bit.
// - Pins are remap inputs at direction 1, remap outputs at direction 0 with their remap enable bit set.
// - Parallel port functions exist only in the large package variant.
// - Lowest pin feeds external interrupt zero when its direction is 1.
// - Reading an analog pin returns 0.
// - Pull-ups off on output pins, and all off after reset.
// - Shared pull-up control sits at bit 7 of interrupt control two.
`include "port_b_low_map.svh"
module port_b_low_pin_function_mux #(
    parameter bit PKG_44 = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire port_b_pkg::axi_req_t bus_req,
    output port_b_pkg::axi_rsp_t bus_rsp,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic [3:0] pullup_en,
    input wire logic [3:0] debug_claim,
    input wire logic [3:0] remap_out_data,
    output logic [3:0] remap_in_data,
    output logic external_irq_zero,
    input wire logic parallel_port_active,
    input wire logic parallel_port_byte_enable,
    input wire logic parallel_port_addr_two,
    input wire logic parallel_port_addr_three,
    input wire logic reference_clock_out
);
    import port_b_pkg::*;

    port_state_t st;
    port_state_t next_st;
    logic [3:0] pin_sync_q;
    logic wr_commit;

    // Priority of pin functions; debug claim beats everything
    function automatic pin_func_t pin_function(input int idx, input logic claim,
                                               input logic dir, input logic remap_en,
                                               input logic pp_on, input logic ref_en);
        if (claim) begin
            return FN_DEBUG;
        end else if (PKG_44 && pp_on && idx != `PBL_PIN_IRQ) begin
            return FN_PARALLEL;
        end else if (!dir && remap_en) begin
            return FN_REMAP;
        end else if (!dir && ref_en && idx == `PBL_PIN_REF) begin
            return FN_REFCLK;
        end
        return FN_GPIO;
    endfunction

    // Address decode shared by the write and read paths
    function automatic logic reg_known(input logic [`PBL_ADDR_W-1:0] addr);
        if (addr == `PBL_OFS_LATCH) begin
            return 1'b1;
        end else if (addr == `PBL_OFS_DIR) begin
            return 1'b1;
        end else if (addr == `PBL_OFS_INPUT) begin
            return 1'b1;
        end else if (addr == `PBL_OFS_ANALOG) begin
            return 1'b1;
        end else if (addr == `PBL_OFS_ICON2) begin
            return 1'b1;
        end else if (addr == `PBL_OFS_FUNC) begin
            return 1'b1;
        end
        return 1'b0;
    endfunction

    // Pins are sampled only after two flops to avoid metastable reads
    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync_q)
    );

    assign wr_commit = st.aw_held && st.w_held && !st.bvalid;

    // Pin muxing, peripheral inputs and the bus slave
    always_comb begin
        pin_func_t fn;
        logic [3:0] port_read;
        logic [7:0] rd;
        fn = FN_GPIO;
        rd = 8'h00;
        next_st = st;
        // Analog pins read as zero since their input buffer is off
        port_read = pin_sync_q & st.digital & ~debug_claim;
        for (int i = 0; i < 4; i++) begin
            fn = pin_function(i, debug_claim[i], st.dir[i], st.remap_en[i],
                              st.pp_en && parallel_port_active, st.ref_en);
            next_st.pullup_en[i] = 1'b0;
            next_st.remap_in[i] = 1'b0;
            case (fn)
                FN_DEBUG: begin
                    next_st.pin_out[i] = 1'b0;
                    next_st.pin_oe_n[i] = 1'b1;
                end
                FN_PARALLEL: begin
                    next_st.pin_oe_n[i] = 1'b0;
                    if (i == `PBL_PIN_BE) begin
                        next_st.pin_out[i] = parallel_port_byte_enable;
                    end else if (i == `PBL_PIN_A3) begin
                        next_st.pin_out[i] = parallel_port_addr_three;
                    end else begin
                        next_st.pin_out[i] = parallel_port_addr_two;
                    end
                end
                FN_REMAP: begin
                    next_st.pin_out[i] = remap_out_data[i];
                    next_st.pin_oe_n[i] = 1'b0;
                end
                FN_REFCLK: begin
                    next_st.pin_out[i] = reference_clock_out;
                    next_st.pin_oe_n[i] = 1'b0;
                end
                default: begin
                    // Analog setting does not gate the output driver
                    next_st.pin_out[i] = st.latch[i];
                    next_st.pin_oe_n[i] = st.dir[i];
                    next_st.pullup_en[i] = st.dir[i] && !st.pu_dis_n;
                end
            endcase
            if (fn != FN_PARALLEL && fn != FN_DEBUG) begin
                next_st.remap_in[i] = port_read[i] && st.dir[i];
            end
        end
        next_st.irq0 = next_st.remap_in[`PBL_PIN_IRQ];

        // Write channel: address and data are taken in either order
        if (bus_req.awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = bus_req.awaddr;
        end
        if (bus_req.wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = bus_req.wdata[7:0];
            next_st.w_strb0 = bus_req.wstrb[0];
        end
        if (st.bvalid && bus_req.bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_commit) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = reg_known(st.aw_addr) ? `PBL_RESP_OKAY : `PBL_RESP_SLVERR;
            // Only byte lane 0 holds implemented bits
            if (st.w_strb0) begin
                if (st.aw_addr == `PBL_OFS_LATCH || st.aw_addr == `PBL_OFS_INPUT) begin
                    next_st.latch = st.w_data[3:0];
                end else if (st.aw_addr == `PBL_OFS_DIR) begin
                    next_st.dir = st.w_data[3:0];
                end else if (st.aw_addr == `PBL_OFS_ANALOG) begin
                    next_st.digital = st.w_data[3:0];
                end else if (st.aw_addr == `PBL_OFS_ICON2) begin
                    next_st.pu_dis_n = st.w_data[`PBL_BIT_PU_DIS_N];
                end else if (st.aw_addr == `PBL_OFS_FUNC) begin
                    next_st.remap_en = st.w_data[3:0];
                    next_st.pp_en = st.w_data[`PBL_BIT_FUNC_PP];
                    next_st.ref_en = st.w_data[`PBL_BIT_FUNC_REF];
                end
            end
        end

        // Read channel: one cycle to answer, held until rready
        if (st.rvalid && bus_req.rready) begin
            next_st.rvalid = 1'b0;
        end
        if (bus_req.arvalid && !st.rvalid) begin
            if (bus_req.araddr == `PBL_OFS_LATCH) begin
                rd = {4'h0, st.latch};
            end else if (bus_req.araddr == `PBL_OFS_DIR) begin
                rd = {4'h0, st.dir};
            end else if (bus_req.araddr == `PBL_OFS_INPUT) begin
                rd = {4'h0, port_read};
            end else if (bus_req.araddr == `PBL_OFS_ANALOG) begin
                rd = {4'h0, st.digital};
            end else if (bus_req.araddr == `PBL_OFS_ICON2) begin
                rd = {st.pu_dis_n, 7'h00};
            end else if (bus_req.araddr == `PBL_OFS_FUNC) begin
                rd = {2'h0, st.ref_en, st.pp_en, st.remap_en};
            end
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = reg_known(bus_req.araddr) ? `PBL_RESP_OKAY : `PBL_RESP_SLVERR;
        end
    end

    // Whole state in one register; reset puts pins analog with pull-ups off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.latch <= `PBL_RST_LATCH;
            st.dir <= `PBL_RST_DIR;
            st.digital <= `PBL_RST_DIGITAL;
            st.pu_dis_n <= `PBL_RST_PU_DIS_N;
            st.pin_oe_n <= `PBL_RST_OE_N;
        end else begin
            st <= next_st;
        end
    end

    // Handshake readies are combinational, data come from flops
    always_comb begin
        bus_rsp.awready = !st.aw_held;
        bus_rsp.wready = !st.w_held;
        bus_rsp.bvalid = st.bvalid;
        bus_rsp.bresp = st.bresp;
        bus_rsp.arready = !st.rvalid;
        bus_rsp.rvalid = st.rvalid;
        bus_rsp.rdata = {24'h000000, st.rdata};
        bus_rsp.rresp = st.rresp;
    end

    assign pin_out = st.pin_out;
    assign pin_oe_n = st.pin_oe_n;
    assign pullup_en = st.pullup_en;
    assign remap_in_data = st.remap_in;
    assign external_irq_zero = st.irq0;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Pins owned by the parallel port, and pins left to the plain latch drive
    logic [3:0] pp_mask;
    logic [3:0] plain_out;
    assign pp_mask = {4{PKG_44 && st.pp_en && parallel_port_active}} & 4'hE;
    assign plain_out = ~st.dir & ~st.remap_en & ~debug_claim & ~pp_mask
                       & ~({4{st.ref_en}} & 4'h4);

    a_latch_drive: assert property (
        (((pin_out ^ $past(st.latch)) | pin_oe_n) & $past(plain_out)) == 4'h0)
        else $error("output pin does not show the latch");
    a_input_hiz: assert property (
        (~pin_oe_n & $past(st.dir & ~debug_claim & ~pp_mask)) == 4'h0)
        else $error("input pin is driven");
    a_analog_no_input: assert property (
        (remap_in_data & $past(~st.digital)) == 4'h0)
        else $error("analog pin reaches a peripheral input");
    a_reset_analog: assert property (
        $past(rst) |-> st.digital == 4'h0 && st.pu_dis_n && pullup_en == 4'h0)
        else $error("pins not analog with pull-ups off after reset");
    a_debug_quiet: assert property (
        (($past(debug_claim) & (~pin_oe_n | pullup_en | remap_in_data)) == 4'h0))
        else $error("debug pin still carries a function");
    a_pp_override: assert property (
        PKG_44 && st.pp_en && parallel_port_active && !debug_claim[1] |=>
        !pin_oe_n[1] && pin_out[1] == $past(parallel_port_byte_enable))
        else $error("parallel port does not own its pin");
    a_small_pkg: assert property (
        !PKG_44 && st.dir[3] && !debug_claim[3] |=> pin_oe_n[3])
        else $error("parallel port present in small variant");
    a_remap_out: assert property (
        !st.dir[0] && st.remap_en[0] && !debug_claim[0] |=>
        !pin_oe_n[0] && pin_out[0] == $past(remap_out_data[0]))
        else $error("remap output not driven");
    a_irq_zero: assert property (
        pin_in[0] ##2 (st.dir[0] && st.digital[0] && !debug_claim[0]) |=> external_irq_zero)
        else $error("external interrupt zero missed its pin");
    a_read_analog_zero: assert property (
        bus_req.arvalid && !st.rvalid && bus_req.araddr == `PBL_OFS_INPUT |=>
        (st.rdata[3:0] & $past(~st.digital)) == 4'h0)
        else $error("analog pin read back as one");
    a_pullup_off_out: assert property ((pullup_en & ~pin_oe_n) == 4'h0)
        else $error("pull-up on an output pin");
    a_pullup_bit: assert property (
        wr_commit && st.w_strb0 && st.aw_addr == `PBL_OFS_ICON2 |=>
        st.pu_dis_n == $past(st.w_data[`PBL_BIT_PU_DIS_N]) && bus_rsp.bvalid)
        else $error("pull-up control bit not written");

    c_write_done: cover property (wr_commit ##1 bus_rsp.bvalid && bus_req.bready);
    c_read_input: cover property (bus_req.arvalid && bus_req.araddr == `PBL_OFS_INPUT
                                  ##1 bus_rsp.rvalid);
    c_pp_drive: cover property (st.pp_en && parallel_port_active && !pin_oe_n[2]);
    c_debug_claim: cover property (debug_claim[0] ##1 pin_oe_n[0]);
endmodule

//--- board_model.sv
// Board-side model of the four low port pins
module board_model (
    input wire logic clk_sys,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] pullup_en,
    input wire logic [3:0] drive_en,
    input wire logic [3:0] drive_val,
    output logic [3:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] flip = 4'h5;

    // A floating unpulled pin wanders, so nothing may trust its level
    always @(posedge clk_sys) begin
        flip <= ~flip;
    end

    // Device drive wins, then the board, then the weak pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : drive_en[i] ? drive_val[i] :
                pullup_en[i] ? 1'b1 : flip[i];
        end
    end
endmodule

//--- port_b_low_pin_function_mux_test.sv
// Self-checking bench for the low port pin function mux
`include "port_b_low_map.svh"
module port_b_low_pin_function_mux_test;
    timeunit 1ns;
    timeprecision 100ps;
    import port_b_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    axi_req_t req = '0;
    axi_rsp_t rsp;
    logic [3:0] pin_in, pin_out, pin_oe_n, pullup_en, remap_in, small_oe_n;
    logic [3:0] claim = '0, rout = '0, drv_en = '0, drv_val = '0, v;
    logic pp_act = 1'b0, pp_be = 1'b0, pp_a2 = 1'b0, pp_a3 = 1'b0, ref_clk = 1'b0, irq;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    int bad_count = 0, tests_run = 0;

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    port_b_low_pin_function_mux DUT (.clk_sys(clk_sys), .rst(rst), .bus_req(req),
        .bus_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .debug_claim(claim), .remap_out_data(rout),
        .remap_in_data(remap_in), .external_irq_zero(irq), .parallel_port_active(pp_act),
        .parallel_port_byte_enable(pp_be), .parallel_port_addr_two(pp_a2),
        .parallel_port_addr_three(pp_a3), .reference_clock_out(ref_clk));

    board_model board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .drive_en(drv_en), .drive_val(drv_val), .pin_in(pin_in));

    // Small package variant sees the same traffic; it must never drive parallel port pins
    port_b_low_pin_function_mux #(.PKG_44(1'b0)) small_pkg (.clk_sys(clk_sys), .rst(rst),
        .bus_req(req), .bus_rsp(), .pin_in(pin_in), .pin_out(), .pin_oe_n(small_oe_n),
        .pullup_en(), .debug_claim(claim), .remap_out_data(rout), .remap_in_data(),
        .external_irq_zero(), .parallel_port_active(pp_act),
        .parallel_port_byte_enable(pp_be), .parallel_port_addr_two(pp_a2),
        .parallel_port_addr_three(pp_a3), .reference_clock_out(ref_clk));

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // A handshake that never comes ends the run
    task automatic hang(input string nm);
        bad_count++;
        $display("MISMATCH %s expected handshake seen timeout", nm);
        report_and_stop();
    endtask

    // Ready is stable from mid-cycle, so it is read there for the next edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF,
                      input logic [1:0] r = `PBL_RESP_OKAY);
        logic ta, tw, tb;
        wq.push_back(r);
        @(posedge clk_sys);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= {24'($urandom), d};
        req.wstrb <= s;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        tb = 0;
        for (int n = 0; n < 40 && !tb; n++) begin
            @(negedge clk_sys);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = rsp.bvalid;
            @(posedge clk_sys);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end
        req.bready <= 1'b0;
        if (!tb) hang("write");
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] d,
                      input logic [1:0] r = `PBL_RESP_OKAY);
        logic ta, tr;
        rq.push_back({r, 24'h0, d});
        @(posedge clk_sys);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        tr = 0;
        for (int n = 0; n < 40 && !tr; n++) begin
            @(negedge clk_sys);
            ta = req.arvalid && rsp.arready;
            tr = rsp.rvalid;
            @(posedge clk_sys);
            if (ta) req.arvalid <= 1'b0;
        end
        req.rready <= 1'b0;
        if (!tr) hang("read");
    endtask

    // Covers the sync delay with slack; pins are then looked at mid-cycle
    task automatic settle();
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Bus answers are compared in arrival order with the driver's notes
    always @(posedge clk_sys) begin
        if (rsp.bvalid && req.bready) begin
            chk("bresp", 34'(rsp.bresp), 34'(wq.pop_front()));
        end
        if (rsp.rvalid && req.rready) begin
            chk("rdata", {rsp.rresp, rsp.rdata}, rq.pop_front());
        end
    end

    // Main sequence
    initial begin
        void'($urandom(93845));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`PBL_OFS_LATCH, 8'h00);
        rd(`PBL_OFS_DIR, 8'h0F);
        rd(`PBL_OFS_INPUT, 8'h00);
        rd(`PBL_OFS_ANALOG, 8'h00);
        rd(`PBL_OFS_ICON2, 8'h80);
        rd(`PBL_OFS_FUNC, 8'h00);
        settle();
        chk("oe_n", 34'(pin_oe_n), 34'hF);
        chk("pullup", 34'(pullup_en), 34'h0);
        rd(6'h18, 8'h00, `PBL_RESP_SLVERR);
        rd(6'h02, 8'h00, `PBL_RESP_SLVERR);
        wr(6'h18, 8'hFF, 4'hF, `PBL_RESP_SLVERR);
        // Outputs stay driven while the pins are still analog
        v = 4'($urandom);
        wr(`PBL_OFS_ICON2, 8'h00);
        wr(`PBL_OFS_DIR, 8'h00);
        wr(`PBL_OFS_LATCH, {4'h0, v});
        wr(`PBL_OFS_LATCH, {4'h0, ~v}, 4'hE);
        settle();
        chk("out", 34'(pin_out), 34'(v));
        chk("oe_n", 34'(pin_oe_n), 34'h0);
        chk("pullup", 34'(pullup_en), 34'h0);
        rd(`PBL_OFS_LATCH, {4'h0, v});
        // Digital inputs, first floating on the pull-ups, then board driven
        wr(`PBL_OFS_DIR, 8'h0F);
        wr(`PBL_OFS_ANALOG, 8'h0F);
        settle();
        chk("pullup", 34'(pullup_en), 34'hF);
        rd(`PBL_OFS_INPUT, 8'h0F);
        v = 4'($urandom);
        drv_val <= v;
        drv_en <= 4'hF;
        settle();
        chk("remap_in", 34'(remap_in), 34'(v));
        chk("irq", 34'(irq), 34'(v[0]));
        rd(`PBL_OFS_INPUT, {4'h0, v});
        wr(`PBL_OFS_ANALOG, 8'h00);
        settle();
        chk("remap_in", 34'(remap_in), 34'h0);
        rd(`PBL_OFS_INPUT, 8'h00);
        // Remapped peripheral outputs
        v = 4'($urandom);
        wr(`PBL_OFS_DIR, 8'h00);
        wr(`PBL_OFS_FUNC, 8'h0F);
        rout <= v;
        settle();
        chk("out", 34'(pin_out), 34'(v));
        chk("oe_n", 34'(pin_oe_n), 34'h0);
        // Parallel port takes pins 1 to 3 whatever their direction
        v = 4'($urandom);
        wr(`PBL_OFS_DIR, 8'h0F);
        wr(`PBL_OFS_FUNC, 8'h10);
        pp_act <= 1'b1;
        pp_be <= v[1];
        pp_a3 <= v[2];
        pp_a2 <= v[3];
        settle();
        chk("pp_oe_n", 34'(pin_oe_n), 34'h1);
        chk("pp_out", 34'(pin_out[3:1]), 34'(v[3:1]));
        chk("small_oe_n", 34'(small_oe_n), 34'hF);
        // Reference clock on pin 2
        wr(`PBL_OFS_DIR, 8'h0B);
        wr(`PBL_OFS_FUNC, 8'h20);
        pp_act <= 1'b0;
        ref_clk <= 1'b1;
        settle();
        chk("ref", 34'(pin_out[2]), 34'h1);
        chk("ref_oe_n", 34'(pin_oe_n), 34'hB);
        // Both levels, so a latch bit that happens to match cannot hide the mux
        @(posedge clk_sys);
        ref_clk <= 1'b0;
        settle();
        chk("ref", 34'(pin_out[2]), 34'h0);
        // Debug claim shuts off every other function
        wr(`PBL_OFS_ANALOG, 8'h0F);
        claim <= 4'hF;
        settle();
        chk("dbg_oe_n", 34'(pin_oe_n), 34'hF);
        chk("dbg_pullup", 34'(pullup_en), 34'h0);
        chk("dbg_remap", 34'(remap_in), 34'h0);
        report_and_stop();
    end
endmodule
